// >>> inc/vsg_pkg.sv
// Shared constants and types of the VME slave glue controller.
package vsg_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses, one aligned word each).
	// ------------------------------------------------------------
	localparam logic [7:0] VSG_ADDR_CTRL      = 8'h00; // Enables and decode delay.
	localparam logic [7:0] VSG_ADDR_COMPARE   = 8'h04; // Address compare value, one byte per lane.
	localparam logic [7:0] VSG_ADDR_MASK      = 8'h08; // Compare mask, a one bit takes part.
	localparam logic [7:0] VSG_ADDR_STATUS    = 8'h0c; // Live state, read only.
	localparam logic [7:0] VSG_ADDR_STATUS_ID = 8'h10; // Last captured status/ID word.

	// ------------------------------------------------------------
	// Field positions and reset values.
	// ------------------------------------------------------------
	localparam int VSG_CTRL_IRQ_EN_BIT = 0;  // Lets the local request reach the bus.
	localparam int VSG_CTRL_DLY_LSB    = 8;  // Decode delay in clock cycles.
	localparam int VSG_CTRL_DLY_W      = 4;  // Width of the decode delay field.
	localparam int VSG_STAT_PEND_BIT   = 0;  // Local request pending.
	localparam int VSG_STAT_BUSY_BIT   = 1;  // A bus cycle is in progress.
	localparam int VSG_STAT_BLT_BIT    = 2;  // Upper address latch is in use.
	localparam int VSG_STAT_REG_LSB    = 4;  // Last sampled region number.
	localparam int VSG_STAT_MATCH_LSB  = 8;  // Lane match outputs, active low.
	localparam logic [31:0] VSG_CTRL_RESET    = 32'h0000_0201;
	localparam logic [31:0] VSG_COMPARE_RESET = 32'h0000_0000;
	localparam logic [31:0] VSG_MASK_RESET    = 32'hffff_ffff;

	// ------------------------------------------------------------
	// Timing: address setup before each DRAM strobe.
	// ------------------------------------------------------------
	localparam int VSG_CLK_MHZ        = 250; // Clock rate.
	localparam int VSG_ADDR_SETUP_NS  = 8;   // Least buffer-to-strobe setup time.
	localparam int VSG_ADDR_SETUP_CYC = ((VSG_ADDR_SETUP_NS * VSG_CLK_MHZ + 999) / 1000 < 1) ?
		1 : (VSG_ADDR_SETUP_NS * VSG_CLK_MHZ + 999) / 1000;

	// ------------------------------------------------------------
	// Carriers.
	// ------------------------------------------------------------
	typedef struct packed {
		logic strobe_n;  // Bus data strobes, low during a cycle.
		logic iack_n;    // Daisy chain acknowledge reaching this board, low active.
		logic mux_cycle; // Current strobe carries a multiplexed address.
		logic blt;       // Block transfer in progress.
		logic dram_sel;  // Access targets DRAM rather than I/O.
	} vsg_vme_s;

	typedef struct packed {
		logic row_en; // Row address buffer enable.
		logic col_en; // Column address buffer enable.
		logic ras_n;  // Row strobe, low active.
		logic cas_n;  // Column strobe, low active.
	} vsg_dram_s;

endpackage

// >>> design/vsg_addr_cmp.sv
// Per-lane masked address comparators of the bus transceivers.
`timescale 1ns/1ns
module vsg_addr_cmp
	import vsg_pkg::*;
#(
	parameter int LANES = 4 // Number of 8-bit transceiver lanes.
) (
	input  wire logic               clock_i,   // System clock.
	input  wire logic               rst_i,     // Synchronous reset, active high.
	input  wire logic [8*LANES-1:0] addr_i,    // Bus address bits.
	input  wire logic [8*LANES-1:0] compare_i, // Compare value.
	input  wire logic [8*LANES-1:0] mask_i,    // Mask, a one bit is compared.
	output logic      [LANES-1:0]   match_n_o  // Low when the lane agrees.
);

	// ------------------------------------------------------------
	// One registered comparator per lane.
	// ------------------------------------------------------------
	logic [LANES-1:0] next_match_n; // Lane results before the register.

	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			// A lane disagrees when any compared bit differs.
			assign next_match_n[g] = |((addr_i[8*g +: 8] ^ compare_i[8*g +: 8])
				& mask_i[8*g +: 8]);
		end
	endgenerate

	// One register for all lanes, so the output has a single driver.
	// Registered so the decoder sees a clean level, at one cycle of latency.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			match_n_o <= {LANES{1'b1}};
		end else begin
			match_n_o <= next_match_n;
		end
	end

	a_lane_match : assert property (@(posedge clock_i) disable iff (rst_i)
		!$past(rst_i) |-> (match_n_o[0] ==
		(((($past(addr_i) ^ $past(compare_i)) & $past(mask_i)) & 32'h0000_00ff) != 0)))
		else $error("Lane 0 match output disagrees with masked compare.");

endmodule // vsg_addr_cmp

// >>> design/vsg_core.sv
// VME slave controller core: interrupter, region sampling, DRAM and latch control.
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ns
module vsg_core
	import vsg_pkg::*;
#(
	parameter int LANES = 4 // Transceiver lanes.
) (
	input  wire logic              clock_i,                 // System clock.
	input  wire logic              rst_i,                   // Synchronous reset, active high.
	input  wire logic [7:0]        paddr_i,                 // APB address.
	input  wire logic              psel_i,                  // APB select.
	input  wire logic              penable_i,               // APB enable.
	input  wire logic              pwrite_i,                // APB direction.
	input  wire logic [31:0]       pwdata_i,                // APB write data.
	output logic      [31:0]       prdata_o,                // APB read data.
	output logic                   pready_o,                // APB ready.
	output logic                   pslverr_o,               // APB error on unmapped address.
	input  wire vsg_vme_s          vme_i,                   // Bus cycle controls.
	input  wire logic [8*LANES-1:0] vme_addr_i,             // Bus address.
	input  wire logic [3:0]        region_i,                // Region from the local decoder.
	input  wire logic              shared_local_irq_n_i,    // Shared local request, low active.
	input  wire logic [31:0]       local_data_bus_i,        // Local data bus.
	output logic                   vme_irq_n_o,             // Bus interrupt request, low active.
	output logic                   local_data_drive_en_n_o, // Asks local logic to drive data.
	output logic      [LANES-1:0]  addr_match_n_o,          // Lane matches, low active.
	output logic                   region_strobe_o,         // Pulse when region is sampled.
	output logic      [3:0]        region_o,                // Sampled region.
	output logic                   upper_addr_latch_o,      // Captures upper address bits.
	output logic                   upper_addr_out_en_n_o,   // Drives the latched address out.
	output vsg_dram_s              dram_o,                  // DRAM buffer and strobe controls.
	output logic      [31:0]       status_id_o              // Status/ID word for the bus.
);

	// ------------------------------------------------------------
	// Registers and state.
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE, ST_DELAY, ST_ROW, ST_RAS, ST_COL, ST_CAS, ST_IACK_REQ, ST_IACK_CAP, ST_HOLD
	} vsg_state_e;

	vsg_state_e state;       // Bus cycle sequencer.
	logic [31:0] ctrl;       // Control register.
	logic [31:0] compare;    // Compare value register.
	logic [31:0] mask;       // Mask register.
	logic [3:0]  cnt;        // Delay and setup counter.
	logic        strobe_q;   // Strobe level one cycle back, for edge finding.
	logic        blt_active; // A multiplexed block transfer holds the latches.
	logic        addr_beat;  // Current strobe is the address beat.
	logic        start;      // Falling edge of the strobes.
	logic        irq_pend;   // Local request seen.
	logic        hit;        // Address decodes to a register.
	logic [31:0] rd_mux;     // Read data selected by address.

	assign start    = strobe_q & ~vme_i.strobe_n;
	assign irq_pend = ~shared_local_irq_n_i;

	// ------------------------------------------------------------
	// APB slave.
	// ------------------------------------------------------------
	// Zero wait states: read data is loaded in the setup cycle and stands in the access cycle.
	assign pready_o = 1'b1;
	assign hit = (paddr_i == VSG_ADDR_CTRL) || (paddr_i == VSG_ADDR_COMPARE) ||
		(paddr_i == VSG_ADDR_MASK) || (paddr_i == VSG_ADDR_STATUS) ||
		(paddr_i == VSG_ADDR_STATUS_ID);
	assign pslverr_o = psel_i & penable_i & ~hit;

	// Read multiplexer; an unmapped address reads as zero.
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (paddr_i)
			VSG_ADDR_CTRL:      rd_mux = ctrl;
			VSG_ADDR_COMPARE:   rd_mux = compare;
			VSG_ADDR_MASK:      rd_mux = mask;
			VSG_ADDR_STATUS: begin
				rd_mux[VSG_STAT_PEND_BIT] = irq_pend;
				rd_mux[VSG_STAT_BUSY_BIT] = (state != ST_IDLE);
				rd_mux[VSG_STAT_BLT_BIT]  = blt_active;
				rd_mux[VSG_STAT_REG_LSB +: 4] = region_o;
				rd_mux[VSG_STAT_MATCH_LSB +: LANES] = addr_match_n_o;
			end
			VSG_ADDR_STATUS_ID: rd_mux = status_id_o;
			default:            rd_mux = 32'h0000_0000;
		endcase
	end

	// Read data register.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (psel_i && !penable_i && !pwrite_i) begin
			prdata_o <= rd_mux;
		end
	end

	// Writable registers take effect at the access edge only.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			ctrl    <= VSG_CTRL_RESET;
			compare <= VSG_COMPARE_RESET;
			mask    <= VSG_MASK_RESET;
		end else if (psel_i && penable_i && pwrite_i) begin
			if (paddr_i == VSG_ADDR_CTRL) begin
				ctrl <= pwdata_i;
			end
			if (paddr_i == VSG_ADDR_COMPARE) begin
				compare <= pwdata_i;
			end
			if (paddr_i == VSG_ADDR_MASK) begin
				mask <= pwdata_i;
			end
		end
	end

	a_ctrl_write : assert property (@(posedge clock_i) disable iff (rst_i)
		psel_i && penable_i && pwrite_i && paddr_i == VSG_ADDR_CTRL
		|=> ctrl == $past(pwdata_i))
		else $error("Control register did not take the written value.");

	// ------------------------------------------------------------
	// Transceiver comparators.
	// ------------------------------------------------------------
	vsg_addr_cmp #(
		.LANES(LANES)
	) u_cmp (
		.clock_i  (clock_i),
		.rst_i    (rst_i),
		.addr_i   (vme_addr_i),
		.compare_i(compare[8*LANES-1:0]),
		.mask_i   (mask[8*LANES-1:0]),
		.match_n_o(addr_match_n_o)
	);

	// ------------------------------------------------------------
	// Interrupter.
	// ------------------------------------------------------------
	// A local request, when enabled, raises the bus request one cycle later.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			vme_irq_n_o <= 1'b1;
		end else begin
			vme_irq_n_o <= ~(irq_pend & ctrl[VSG_CTRL_IRQ_EN_BIT]);
		end
	end

	a_irq_follow : assert property (@(posedge clock_i) disable iff (rst_i)
		irq_pend && ctrl[VSG_CTRL_IRQ_EN_BIT] |=> !vme_irq_n_o)
		else $error("Local request did not raise the bus interrupt.");

	// ------------------------------------------------------------
	// Bus cycle sequencer.
	// ------------------------------------------------------------
	// Strobe history for the start edge.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			strobe_q <= 1'b1;
		end else begin
			strobe_q <= vme_i.strobe_n;
		end
	end

	// The sequencer; a strobe release ends any cycle at once, so a short master cannot hang it.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			cnt   <= 4'h0;
		end else if (state != ST_IDLE && vme_i.strobe_n) begin
			state <= ST_IDLE;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (start && !vme_i.iack_n && irq_pend) begin
						state <= ST_IACK_REQ;
					end else if (start) begin
						state <= ST_DELAY;
						cnt   <= ctrl[VSG_CTRL_DLY_LSB +: VSG_CTRL_DLY_W];
					end
				end
				ST_DELAY: begin
					// The region inputs are only trusted once the delay has run out.
					if (cnt != 4'h0) begin
						cnt <= cnt - 4'h1;
					end else if (vme_i.dram_sel) begin
						state <= ST_ROW;
						cnt   <= 4'(VSG_ADDR_SETUP_CYC - 1);
					end else begin
						state <= ST_HOLD;
					end
				end
				ST_ROW: begin
					// Row buffer settles before RAS falls.
					if (cnt != 4'h0) begin
						cnt <= cnt - 4'h1;
					end else begin
						state <= ST_RAS;
					end
				end
				ST_RAS: begin
					state <= ST_COL;
					cnt   <= 4'(VSG_ADDR_SETUP_CYC - 1);
				end
				ST_COL: begin
					// Column buffer settles before CAS falls.
					if (cnt != 4'h0) begin
						cnt <= cnt - 4'h1;
					end else begin
						state <= ST_CAS;
					end
				end
				ST_CAS:      state <= ST_CAS;
				ST_IACK_REQ: state <= ST_IACK_CAP;
				ST_IACK_CAP: state <= ST_HOLD;
				ST_HOLD:     state <= ST_HOLD;
				default:     state <= ST_IDLE;
			endcase
		end
	end

	// Region sampling after the decode delay.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			region_o        <= 4'h0;
			region_strobe_o <= 1'b0;
		end else begin
			region_strobe_o <= (state == ST_DELAY) && (cnt == 4'h0) && !vme_i.strobe_n;
			if ((state == ST_DELAY) && (cnt == 4'h0) && !vme_i.strobe_n) begin
				region_o <= region_i;
			end
		end
	end

	a_decode_wait : assert property (@(posedge clock_i) disable iff (rst_i)
		region_strobe_o |-> $past(state) == ST_DELAY && $past(cnt) == 4'h0)
		else $error("Region sampled before the decode delay ran out.");

	a_delay_holds : assert property (@(posedge clock_i) disable iff (rst_i)
		state == ST_DELAY && cnt != 4'h0 && !vme_i.strobe_n |=> state == ST_DELAY)
		else $error("Decode delay left early.");

	// ------------------------------------------------------------
	// DRAM controls and acknowledge data request.
	// ------------------------------------------------------------
	// Decoded from the state register, so each control changes at most once per state change.
	always_comb begin
		dram_o.row_en = (state == ST_ROW) || (state == ST_RAS);
		dram_o.col_en = (state == ST_COL) || (state == ST_CAS);
		dram_o.ras_n  = !((state == ST_RAS) || (state == ST_COL) || (state == ST_CAS));
		dram_o.cas_n  = !(state == ST_CAS);
		local_data_drive_en_n_o = !((state == ST_IACK_REQ) || (state == ST_IACK_CAP));
	end

	a_ras_then_cas : assert property (@(posedge clock_i) disable iff (rst_i)
		$fell(dram_o.cas_n) |-> !dram_o.ras_n && !$past(dram_o.ras_n) && dram_o.col_en)
		else $error("CAS fell without RAS held and column buffer on.");

	a_row_first : assert property (@(posedge clock_i) disable iff (rst_i)
		$fell(dram_o.ras_n) |-> $past(dram_o.row_en) && dram_o.row_en && dram_o.cas_n)
		else $error("RAS fell without the row buffer enabled.");

	// Status/ID capture at the second cycle of the local drive window.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			status_id_o <= 32'h0000_0000;
		end else if (state == ST_IACK_CAP) begin
			status_id_o <= local_data_bus_i;
		end
	end

	a_iack_drive : assert property (@(posedge clock_i) disable iff (rst_i)
		state == ST_IDLE && start && !vme_i.iack_n && irq_pend
		|=> !local_data_drive_en_n_o ##1 (!local_data_drive_en_n_o || $past(vme_i.strobe_n)))
		else $error("Acknowledge did not ask local logic for the status word.");

	a_iack_capture : assert property (@(posedge clock_i) disable iff (rst_i)
		state == ST_IACK_CAP |=> status_id_o == $past(local_data_bus_i))
		else $error("Status word not captured from the local data bus.");

	// ------------------------------------------------------------
	// Upper address latch control for multiplexed block transfers.
	// ------------------------------------------------------------
	// Latch pulses on the address beat; the latch drives out on later beats of the block.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			upper_addr_latch_o <= 1'b0;
			blt_active         <= 1'b0;
			addr_beat          <= 1'b0;
		end else begin
			upper_addr_latch_o <= start & vme_i.mux_cycle;
			if (start && vme_i.mux_cycle && vme_i.blt) begin
				blt_active <= 1'b1;
			end else if (!vme_i.blt) begin
				blt_active <= 1'b0;
			end
			if (start) begin
				addr_beat <= vme_i.mux_cycle;
			end else if (vme_i.strobe_n) begin
				addr_beat <= 1'b0;
			end
		end
	end

	assign upper_addr_out_en_n_o = !(blt_active && !addr_beat && !vme_i.strobe_n);

	a_latch_pulse : assert property (@(posedge clock_i) disable iff (rst_i)
		start && vme_i.mux_cycle |=> upper_addr_latch_o ##1 !upper_addr_latch_o)
		else $error("Upper address latch pulse missing or too long.");

endmodule // vsg_core

// >>> test/vsg_local_model.sv
// Behavioural model of the local interrupt logic and region decoder beside the core.
`timescale 1ns/1ns
module vsg_local_model
	import vsg_pkg::*;
#(
	parameter logic [3:0]  BOARD_BASE = 4'ha,          // Board base nibble.
	parameter logic [31:0] INIT_WORD  = 32'h0000_00c3, // Initialisation status/ID word.
	parameter logic [2:0]  MODE_A32   = 3'h1,          // Upper modifier bits of a 32-bit cycle.
	parameter logic [2:0]  MODE_A40   = 3'h3           // Upper modifier bits of a 40-bit cycle.
) (
	input  wire logic        clock_i,                 // System clock.
	input  wire logic        rst_i,                   // Synchronous reset, active high.
	input  wire logic [3:0]  source_irq_n_i,          // Four local requests, low active.
	input  wire logic        local_data_drive_en_n_i, // Core asks for a data word.
	input  wire logic        module_bus_request_n_i,  // Module bus request, low active.
	input  wire logic        prom_enable_n_i,         // Serial PROM enable, low active.
	input  wire logic [31:0] vme_addr_i,              // Bus address.
	input  wire logic [5:0]  am_code_i,               // Address-modifier code of the cycle.
	input  wire logic [31:0] vme_data_i,              // Bus data, upper address bits in A40.
	input  wire logic [3:0]  byte_enables_i,          // Byte enables of the access.
	input  wire logic        dram_cas_n_i,            // Core column strobe, low active.
	input  wire logic        dram_sel_i,              // Access targets DRAM.
	input  wire logic        dram_mode_i,             // High when only three region bits are used.
	output logic             shared_local_irq_n_o,    // Shared request, low active.
	output logic [31:0]      local_data_bus_o,        // Local data bus.
	output logic [3:0]       cas_lines_n_o,           // Per-byte column strobes, low active.
	output logic [3:0]       region_o                 // Region number for the core.
);
	// ------------------------------------------------------------
	// Interrupt priority and data drive.
	// ------------------------------------------------------------
	logic [31:0] drive_val; // Word this logic would drive.
	logic [31:0] held;      // Last word driven, inverted once released.
	logic        drive;     // All drive conditions met.

	assign shared_local_irq_n_o = &source_irq_n_i;
	assign drive = !local_data_drive_en_n_i && module_bus_request_n_i && prom_enable_n_i;

	// Lowest source index wins, so the loop runs from the lowest priority up.
	always_comb begin
		drive_val = INIT_WORD;
		for (int i = 3; i >= 0; i--) begin
			if (!source_irq_n_i[i]) begin
				drive_val = 32'h0000_0011 + i;
			end
		end
	end

	// A released bus must not keep showing a valid word, so it shows the inverse.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			held <= 32'h0;
		end else if (drive) begin
			held <= drive_val;
		end
	end
	assign local_data_bus_o = drive ? drive_val : ~held;

	// ------------------------------------------------------------
	// Region decoder and column strobe gating.
	// ------------------------------------------------------------
	logic [7:0] top_bits; // Board nibble and region nibble for the current mode.

	// The mode says where the top address bits lie; an unknown mode lands in the dead region.
	always_comb begin
		case (am_code_i[5:3])
			MODE_A32: top_bits = vme_addr_i[31:24];
			MODE_A40: top_bits = vme_data_i[15:8];
			default:  top_bits = {~BOARD_BASE, 4'h0};
		endcase
		if (top_bits[7:4] != BOARD_BASE) begin
			region_o = 4'h0;
		end else begin
			region_o = {top_bits[3] & !dram_mode_i, top_bits[2:0]};
		end
	end

	// Only DRAM accesses reach the column strobes.
	assign cas_lines_n_o = (dram_cas_n_i || !dram_sel_i) ? 4'hf : ~byte_enables_i;
endmodule // vsg_local_model

// >>> test/vme_slave_region_irq_glue_bench.sv
// Self-checking bench of the controller core with its local-side model.
`timescale 1ns/1ns
module vme_slave_region_irq_glue_bench
	import vsg_pkg::*;
;
	// ------------------------------------------------------------
	// Signals.
	// ------------------------------------------------------------
	localparam vsg_vme_s    IDLE_BUS = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0}; // No cycle.
	localparam logic [7:0]  ADDRS [4] = '{VSG_ADDR_CTRL, VSG_ADDR_COMPARE, VSG_ADDR_MASK, 8'h14};
	localparam logic [31:0] RSTS [4]  = '{VSG_CTRL_RESET, VSG_COMPARE_RESET, VSG_MASK_RESET, 32'h0};
	logic        clock_i = 1'b0;      // System clock.
	logic        rst_i = 1'b1;        // Reset.
	logic        psel = 1'b0;         // APB select.
	logic        penable = 1'b0;      // APB enable.
	logic        pwrite = 1'b0;       // APB direction.
	logic [7:0]  paddr = 8'h00;       // APB address.
	logic [31:0] pwdata = 32'h0;      // APB write data.
	vsg_vme_s    vme = IDLE_BUS;      // Bus cycle controls.
	logic [31:0] vme_addr = 32'h0;    // Bus address.
	logic [3:0]  sources = 4'hf;      // Local requests, low active.
	logic [5:0]  am = 6'h08;          // Address-modifier code.
	logic        dram_mode = 1'b0;    // Three region bits when high.
	logic [31:0] prdata, ldata, status_id;
	logic        pready, pslverr, irq_n, shared_n, drive_en_n, rstrobe, latch, out_en_n;
	logic [3:0]  match_n, region, region_q, cas_lines;
	vsg_dram_s   dram;
	logic [4:0]  probe;               // Watched single-bit outputs.
	logic [31:0] rd;                  // Last read word.
	logic        er;                  // Last error response.
	int          err_total = 0;
	int          cmp_count = 0;
	int          cyc = 0;

	assign probe = {dram.cas_n, dram.ras_n, drive_en_n, latch, rstrobe};

	vsg_core #(.LANES(4)) dut_u (.clock_i(clock_i), .rst_i(rst_i), .paddr_i(paddr),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .vme_i(vme),
		.vme_addr_i(vme_addr), .region_i(region), .shared_local_irq_n_i(shared_n),
		.local_data_bus_i(ldata), .vme_irq_n_o(irq_n), .local_data_drive_en_n_o(drive_en_n),
		.addr_match_n_o(match_n), .region_strobe_o(rstrobe), .region_o(region_q),
		.upper_addr_latch_o(latch), .upper_addr_out_en_n_o(out_en_n), .dram_o(dram),
		.status_id_o(status_id));

	// The multiplexed upper address bits ride on the same word as the address here.
	vsg_local_model model_u (.clock_i(clock_i), .rst_i(rst_i), .source_irq_n_i(sources),
		.local_data_drive_en_n_i(drive_en_n), .module_bus_request_n_i(1'b1),
		.prom_enable_n_i(1'b1), .vme_addr_i(vme_addr), .am_code_i(am),
		.vme_data_i(vme_addr), .byte_enables_i(4'h5), .dram_cas_n_i(dram.cas_n),
		.dram_sel_i(vme.dram_sel), .dram_mode_i(dram_mode), .shared_local_irq_n_o(shared_n),
		.local_data_bus_o(ldata), .cas_lines_n_o(cas_lines), .region_o(region));

	// ------------------------------------------------------------
	// Shared tasks.
	// ------------------------------------------------------------
	task conclude;
		$display("Counts: %0d mismatches, %0d comparisons", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One APB transfer; the request is held until pready is seen at an edge.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clock_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock_i);
		penable <= 1'b1;
		@(posedge clock_i);
		while (pready !== 1'b1) begin
			@(posedge clock_i);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Waits a bounded time for one watched output to reach a level.
	task wait_bit(input int b, input logic lvl);
		int n;
		n = 0;
		while (probe[b] !== lvl && n < 64) begin
			@(posedge clock_i);
			n++;
		end
		chk({31'h0, probe[b]}, {31'h0, lvl});
	endtask

	// ------------------------------------------------------------
	// Scenarios.
	// ------------------------------------------------------------
	task t_regs;
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, ADDRS[i], 32'h0);
			chk(rd, RSTS[i]);
			chk({31'h0, er}, {31'h0, i == 3});
		end
	endtask

	task t_compare;
		apb(1'b1, VSG_ADDR_COMPARE, 32'h1234_5678);
		apb(1'b1, VSG_ADDR_MASK, 32'hffff_00ff);
		vme_addr <= 32'h1234_aa78;
		repeat (3) @(posedge clock_i);
		chk({28'h0, match_n}, 32'h0);
		vme_addr <= 32'h1234_5679;
		repeat (3) @(posedge clock_i);
		chk({28'h0, match_n}, 32'h1);
	endtask

	// Request raised, masked by the enable, restored and cleared.
	task t_irq;
		sources <= 4'b1011;
		repeat (3) @(posedge clock_i);
		chk({31'h0, irq_n}, 32'h0);
		apb(1'b1, VSG_ADDR_CTRL, 32'h0000_0200);
		repeat (3) @(posedge clock_i);
		chk({31'h0, irq_n}, 32'h1);
		apb(1'b1, VSG_ADDR_CTRL, VSG_CTRL_RESET);
		repeat (3) @(posedge clock_i);
		chk({31'h0, irq_n}, 32'h0);
		sources <= 4'hf;
		repeat (3) @(posedge clock_i);
		chk({31'h0, irq_n}, 32'h1);
	endtask

	// Source i and all lower-priority ones pending; source i must win.
	task t_ack;
		for (int i = 0; i < 4; i++) begin
			sources <= ~(4'hf << i);
			repeat (3) @(posedge clock_i);
			vme <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
			wait_bit(2, 1'b0);
			wait_bit(2, 1'b1);
			@(posedge clock_i);
			chk(status_id, 32'h0000_0011 + i);
			vme <= IDLE_BUS;
			sources <= 4'hf;
			repeat (3) @(posedge clock_i);
		end
	endtask

	// One DRAM cycle with a given address, modifier code and region mode.
	task t_cycle(input logic [31:0] a, input logic [5:0] m, input logic dm, input logic [3:0] exp);
		vme_addr <= a;
		am <= m;
		dram_mode <= dm;
		@(posedge clock_i);
		vme <= '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
		wait_bit(0, 1'b1);
		chk({28'h0, region_q}, {28'h0, exp});
		wait_bit(3, 1'b0);
		chk({31'h0, dram.row_en}, 32'h1);
		wait_bit(4, 1'b0);
		chk({30'h0, dram.col_en, dram.ras_n}, 32'h2);
		chk({28'h0, cas_lines}, 32'ha);
		vme <= IDLE_BUS;
		repeat (3) @(posedge clock_i);
		chk({28'h0, dram}, 32'h3);
	endtask

	// Multiplexed block transfer: the capture pulse lasts one cycle, and the latch
	// drives out only on a later data beat of the same block.
	task t_latch;
		vme <= '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
		wait_bit(1, 1'b1);
		chk({31'h0, out_en_n}, 32'h1);
		@(posedge clock_i);
		chk({31'h0, latch}, 32'h0);
		vme <= '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
		repeat (2) @(posedge clock_i);
		vme <= '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
		repeat (2) @(posedge clock_i);
		chk({31'h0, out_en_n}, 32'h0);
		chk({31'h0, latch}, 32'h0);
		vme <= IDLE_BUS;
		repeat (3) @(posedge clock_i);
		chk({31'h0, out_en_n}, 32'h1);
	endtask

	// ------------------------------------------------------------
	// Clock, timeout and main sequence.
	// ------------------------------------------------------------
	initial begin
		forever #2 clock_i = ~clock_i;
	end

	// The whole run needs well under a thousand cycles; a hang stops here.
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			conclude;
		end
	end

	initial begin
		repeat (6) @(posedge clock_i);
		rst_i <= 1'b0;
		t_regs;
		t_compare;
		t_irq;
		t_ack;
		t_cycle(32'had00_0000, 6'h08, 1'b0, 4'hd);
		t_cycle(32'had00_0000, 6'h08, 1'b1, 4'h5);
		t_cycle(32'h3500_0000, 6'h08, 1'b0, 4'h0);
		t_cycle(32'h0000_a700, 6'h18, 1'b0, 4'h7);
		t_cycle(32'had00_0000, 6'h38, 1'b0, 4'h0);
		t_latch;
		conclude;
	end
endmodule // vme_slave_region_irq_glue_bench
